//--- tws_pkg.sv
/*
  Constants, types and register map of the two-wire slave control.
  Assumes one system clock and an 8-bit register port.
*/
package tws_pkg;
  // Register byte addresses
  localparam logic [7:0] TWS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] TWS_ADDR_STAT = 8'h04;
  localparam logic [7:0] TWS_ADDR_DATA = 8'h08;
  localparam logic [7:0] TWS_ADDR_OWN = 8'h0C;
  localparam logic [7:0] TWS_ADDR_INTST = 8'h10;
  localparam logic [7:0] TWS_ADDR_INTMSK = 8'h14;
  // Control register bit positions
  localparam int TWS_CTRL_FLAG = 7;
  localparam int TWS_CTRL_ACKEN = 6;
  localparam int TWS_CTRL_STA = 5;
  localparam int TWS_CTRL_STO = 4;
  localparam int TWS_CTRL_EN = 2;
  // Interrupt status bit positions
  localparam int TWS_INT_DONE = 0;
  localparam int TWS_INT_ARB = 1;
  localparam int TWS_INT_WAKE = 2;
  // Status codes, prescaler bits always zero
  localparam logic [7:0] TWS_ST_START = 8'h08;
  localparam logic [7:0] TWS_ST_SRW = 8'h60;
  localparam logic [7:0] TWS_ST_SRW_ARB = 8'h68;
  localparam logic [7:0] TWS_ST_GC = 8'h70;
  localparam logic [7:0] TWS_ST_GC_ARB = 8'h78;
  localparam logic [7:0] TWS_ST_RX_ACK = 8'h80;
  localparam logic [7:0] TWS_ST_RX_NACK = 8'h88;
  localparam logic [7:0] TWS_ST_GRX_ACK = 8'h90;
  localparam logic [7:0] TWS_ST_GRX_NACK = 8'h98;
  localparam logic [7:0] TWS_ST_STR = 8'hA8;
  localparam logic [7:0] TWS_ST_STR_ARB = 8'hB0;
  localparam logic [7:0] TWS_ST_TX_ACK = 8'hB8;
  localparam logic [7:0] TWS_ST_TX_NACK = 8'hC0;
  localparam logic [7:0] TWS_ST_TX_LAST = 8'hC8;
  localparam logic [7:0] TWS_ST_NOINFO = 8'hF8;
  // General call address
  localparam logic [6:0] TWS_GC_ADDR = 7'h00;
  // Timing
  localparam int TWS_CLK_PERIOD_NS = 10;
  localparam int TWS_T_HD_STA_NS = 4000;
  localparam logic [8:0] TWS_T_HD_STA_CYC =
    9'((TWS_T_HD_STA_NS + TWS_CLK_PERIOD_NS - 1) / TWS_CLK_PERIOD_NS);

  // Controller states
  typedef enum logic [3:0] {
    TWS_IDLE = 4'h0,
    TWS_ADDR = 4'h1,
    TWS_AACK = 4'h2,
    TWS_HOLD = 4'h3,
    TWS_RXD = 4'h4,
    TWS_RXACK = 4'h5,
    TWS_TXD = 4'h6,
    TWS_TXACK = 4'h7,
    TWS_MSTART = 4'h8,
    TWS_MEND = 4'h9,
    TWS_IGNORE = 4'hA
  } tws_fsm_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tws_bus_req_t;

  // Whole module state
  typedef struct packed {
    logic sclS1, sclS2, sclPrev;
    logic sdaS1, sdaS2, sdaPrev;
    tws_fsm_t st;
    tws_fsm_t holdNext;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [8:0] cnt;
    logic isTx, isGc, lastByte, ackSeen;
    logic flag, ackEn, startReq, stopReq, enable;
    logic [7:0] status;
    logic [7:0] dataReg;
    logic [7:0] ownAddr;
    logic [2:0] intSt;
    logic [2:0] intMask;
    logic [7:0] rdData;
    logic sdaOe, sclOe;
    logic busy, startPend, wake;
  } tws_state_t;

  localparam tws_state_t TWS_STATE_RST = '{
    sclS1: 1'b1, sclS2: 1'b1, sclPrev: 1'b1,
    sdaS1: 1'b1, sdaS2: 1'b1, sdaPrev: 1'b1,
    st: TWS_IDLE, holdNext: TWS_IDLE,
    status: TWS_ST_NOINFO,
    default: '0
  };
endpackage

//--- tws_slave_ctrl.sv
/*
  Slave control of a byte-oriented two-wire serial interface:
  address and general-call recognition, acknowledge control,
  slave receive and transmit, clock stretching, start request
  and wake from deep sleep.
  Assumes open-drain SCL and SDA resolved outside, and a
  register master on ref_clk that never waits.
*/
`timescale 1ns/100ps
module tws_slave_ctrl
  import tws_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Async reset, low
  input wire tws_bus_req_t busReq, // Register request
  output logic [7:0] rdData, // Read data, next cycle
  input wire logic sclIn, // SCL wire level
  output logic sclOut, // SCL drive value
  output logic sclOe, // SCL pull low enable
  input wire logic sdaIn, // SDA wire level
  output logic sdaOut, // SDA drive value
  output logic sdaOe, // SDA pull low enable
  input wire logic deepSleep, // Non-idle sleep active
  output logic wakeReq, // Wake request level
  output logic irq // Interrupt level
);

  tws_state_t s; // Current state
  tws_state_t n; // Next state
  logic sclRise; // SCL rising edge
  logic sclFall; // SCL falling edge
  logic startC; // START seen
  logic stopC; // STOP seen
  logic ownHit; // Own address match
  logic gcHit; // General call match
  logic arb; // Addressed while start pending

  // Write strobe decode for one register
  function automatic logic wrHit(input tws_bus_req_t r,
                                 input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // Edge and condition detect on synced pins
  assign sclRise = s.sclS2 & ~s.sclPrev;
  assign sclFall = ~s.sclS2 & s.sclPrev;
  assign startC = s.sclS2 & s.sclPrev & s.sdaPrev & ~s.sdaS2;
  assign stopC = s.sclS2 & s.sclPrev & ~s.sdaPrev & s.sdaS2;

  assign ownHit = s.ackEn && (s.shift[7:1] == s.ownAddr[7:1]);
  assign gcHit = s.ackEn && s.ownAddr[0] &&
                 (s.shift[7:1] == TWS_GC_ADDR) && !s.shift[0];
  assign arb = s.startPend;

  // Next state
  always_comb begin
    n = s;
    // Two-stage sync, then edge history
    n.sclS1 = sclIn;
    n.sclS2 = s.sclS1;
    n.sclPrev = s.sclS2;
    n.sdaS1 = sdaIn;
    n.sdaS2 = s.sdaS1;
    n.sdaPrev = s.sdaS2;
    // Wake stays only while asleep
    n.wake = s.wake & deepSleep;

    // Control register write
    if (wrHit(busReq, TWS_ADDR_CTRL)) begin
      n.ackEn = busReq.wdata[TWS_CTRL_ACKEN];
      n.startReq = busReq.wdata[TWS_CTRL_STA];
      n.stopReq = busReq.wdata[TWS_CTRL_STO];
      n.enable = busReq.wdata[TWS_CTRL_EN];
      // Flag cleared by writing one
      if (busReq.wdata[TWS_CTRL_FLAG]) begin
        n.flag = 1'b0;
      end
    end
    // Data and address writes
    if (wrHit(busReq, TWS_ADDR_DATA)) begin
      n.dataReg = busReq.wdata;
    end
    if (wrHit(busReq, TWS_ADDR_OWN)) begin
      n.ownAddr = busReq.wdata;
    end
    // Interrupt status, write one to clear
    if (wrHit(busReq, TWS_ADDR_INTST)) begin
      n.intSt = s.intSt & ~busReq.wdata[2:0];
    end
    if (wrHit(busReq, TWS_ADDR_INTMSK)) begin
      n.intMask = busReq.wdata[2:0];
    end

    // Read data, valid the next cycle only
    n.rdData = 8'h00;
    if (busReq.rd) begin
      case (busReq.addr)
        TWS_ADDR_CTRL: begin
          n.rdData = {s.flag, s.ackEn, s.startReq, s.stopReq,
                      1'b0, s.enable, 2'b00};
        end
        TWS_ADDR_STAT: begin
          // Prescaler and reserved bits read zero
          n.rdData = {s.status[7:3], 3'b000};
        end
        TWS_ADDR_DATA: n.rdData = s.dataReg;
        TWS_ADDR_OWN: n.rdData = s.ownAddr;
        TWS_ADDR_INTST: n.rdData = {5'b00000, s.intSt};
        TWS_ADDR_INTMSK: n.rdData = {5'b00000, s.intMask};
        default: n.rdData = 8'h00;
      endcase
    end

    // Bus busy tracking, kept even when not addressed
    if (startC) begin
      n.busy = 1'b1;
    end
    if (stopC) begin
      n.busy = 1'b0;
    end

    // Bus conditions restart the byte engine outside HOLD, MSTART and MEND
    if (s.st != TWS_HOLD && s.st != TWS_MSTART &&
        s.st != TWS_MEND) begin
      if (startC && s.enable) begin
        n.st = TWS_ADDR;
        n.bitCnt = 4'h0;
        n.sdaOe = 1'b0;
      end else if (stopC) begin
        n.st = TWS_IDLE;
        n.sdaOe = 1'b0;
      end
    end

    // Byte engine
    case (s.st)
      TWS_IDLE: begin
        if (s.startPend && !s.busy && s.enable) begin
          n.st = TWS_MSTART;
          n.cnt = 9'h000;
          n.sdaOe = 1'b1;
        end
      end
      TWS_ADDR: begin
        if (sclRise) begin
          n.shift = {s.shift[6:0], s.sdaS2};
          n.bitCnt = s.bitCnt + 4'h1;
        end else if (sclFall && s.bitCnt == 4'h8) begin
          // Own or general call plus direction
          if (ownHit || gcHit) begin
            n.sdaOe = 1'b1;
            n.st = TWS_AACK;
            n.isTx = s.shift[0];
            n.isGc = gcHit && !ownHit;
          end else begin
            n.st = TWS_IGNORE;
          end
        end
      end
      TWS_AACK: begin
        if (sclFall) begin
          n.sdaOe = 1'b0;
          n.flag = 1'b1;
          n.intSt[TWS_INT_DONE] = 1'b1;
          n.sclOe = 1'b1;
          n.bitCnt = 4'h0;
          n.st = TWS_HOLD;
          if (arb) begin
            n.intSt[TWS_INT_ARB] = 1'b1;
          end
          if (s.isTx) begin
            n.status = arb ? TWS_ST_STR_ARB : TWS_ST_STR;
            n.holdNext = TWS_TXD;
          end else if (s.isGc) begin
            n.status = arb ? TWS_ST_GC_ARB : TWS_ST_GC;
            n.holdNext = TWS_RXD;
          end else begin
            n.status = arb ? TWS_ST_SRW_ARB : TWS_ST_SRW;
            n.holdNext = TWS_RXD;
          end
          if (deepSleep) begin
            n.wake = 1'b1;
            n.intSt[TWS_INT_WAKE] = 1'b1;
          end
        end
      end
      TWS_HOLD: begin
        n.sclOe = 1'b1;
        if (!s.flag) begin
          n.sclOe = 1'b0;
          n.bitCnt = 4'h0;
          if (s.stopReq && s.holdNext != TWS_MEND) begin
            // Software recovery to not-addressed mode
            n.stopReq = 1'b0;
            n.st = TWS_IDLE;
          end else begin
            case (s.holdNext)
              TWS_TXD: begin
                // First bit goes out while SCL still low
                n.shift = s.dataReg;
                n.lastByte = !s.ackEn;
                n.sdaOe = !s.dataReg[7];
                n.bitCnt = 4'h1;
                n.st = TWS_TXD;
              end
              TWS_RXD: n.st = TWS_RXD;
              TWS_MEND: begin
                n.cnt = 9'h000;
                n.st = TWS_MEND;
              end
              default: begin
                if (s.startReq) begin
                  n.startPend = 1'b1;
                end
                n.st = TWS_IDLE;
              end
            endcase
          end
        end
      end
      TWS_RXD: begin
        if (sclRise) begin
          n.shift = {s.shift[6:0], s.sdaS2};
          n.bitCnt = s.bitCnt + 4'h1;
        end else if (sclFall && s.bitCnt == 4'h8) begin
          n.sdaOe = s.ackEn;
          n.lastByte = !s.ackEn;
          n.st = TWS_RXACK;
        end
      end
      TWS_RXACK: begin
        if (sclFall) begin
          n.sdaOe = 1'b0;
          n.flag = 1'b1;
          n.intSt[TWS_INT_DONE] = 1'b1;
          n.sclOe = 1'b1;
          n.st = TWS_HOLD;
          // Data register not loaded in sleep
          if (!deepSleep) begin
            n.dataReg = s.shift;
          end
          if (s.isGc) begin
            n.status = s.lastByte ? TWS_ST_GRX_NACK : TWS_ST_GRX_ACK;
          end else begin
            n.status = s.lastByte ? TWS_ST_RX_NACK : TWS_ST_RX_ACK;
          end
          // Drop to not-addressed mode after NACK
          n.holdNext = s.lastByte ? TWS_IDLE : TWS_RXD;
        end
      end
      TWS_TXD: begin
        if (sclFall) begin
          if (s.bitCnt == 4'h8) begin
            // Release SDA for the master's acknowledge
            n.sdaOe = 1'b0;
            n.st = TWS_TXACK;
          end else begin
            n.shift = {s.shift[6:0], 1'b1};
            n.sdaOe = !s.shift[6];
            n.bitCnt = s.bitCnt + 4'h1;
          end
        end
      end
      TWS_TXACK: begin
        if (sclRise) begin
          n.ackSeen = !s.sdaS2;
        end else if (sclFall) begin
          n.flag = 1'b1;
          n.intSt[TWS_INT_DONE] = 1'b1;
          n.sclOe = 1'b1;
          n.st = TWS_HOLD;
          if (!s.ackSeen) begin
            n.status = TWS_ST_TX_NACK;
          end else if (s.lastByte) begin
            n.status = TWS_ST_TX_LAST;
          end else begin
            n.status = TWS_ST_TX_ACK;
          end
          n.holdNext = (s.ackSeen && !s.lastByte) ? TWS_TXD :
                       TWS_IDLE;
        end
      end
      TWS_IGNORE: begin
        // Wait for next START or STOP
        n.sdaOe = 1'b0;
      end
      TWS_MSTART: begin
        // Hold SDA low with SCL high
        n.sdaOe = 1'b1;
        n.cnt = s.cnt + 9'h001;
        if (s.cnt == TWS_T_HD_STA_CYC - 9'h001) begin
          n.sclOe = 1'b1;
          n.flag = 1'b1;
          n.intSt[TWS_INT_DONE] = 1'b1;
          n.status = TWS_ST_START;
          n.startPend = 1'b0;
          n.startReq = 1'b0;
          n.holdNext = TWS_MEND;
          n.st = TWS_HOLD;
        end
      end
      TWS_MEND: begin
        // SCL released first, then SDA: a STOP
        n.cnt = s.cnt + 9'h001;
        if (s.cnt == TWS_T_HD_STA_CYC - 9'h001) begin
          n.sdaOe = 1'b0;
          n.st = TWS_IDLE;
        end
      end
      default: begin
        n.st = TWS_IDLE;
        n.sdaOe = 1'b0;
        n.sclOe = 1'b0;
      end
    endcase

    // Disabled interface lets go of the bus
    if (!s.enable) begin
      n.st = TWS_IDLE;
      n.sdaOe = 1'b0;
      n.sclOe = 1'b0;
      n.startPend = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= TWS_STATE_RST;
    end else begin
      s <= n;
    end
  end

  // Outputs
  assign rdData = s.rdData;
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = s.sclOe;
  assign sdaOe = s.sdaOe;
  assign wakeReq = s.wake;
  assign irq = |(s.intSt & s.intMask);

endmodule // tws_slave_ctrl

//--- tws_slave_ctrl_chk.sv
/*
  Port checker of the two-wire slave control.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/100ps
module tws_slave_ctrl_chk
  import tws_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Async reset, low
  input wire tws_bus_req_t busReq, // Register request
  input wire logic [7:0] rdData, // Read data
  input wire logic sclIn, // SCL level
  input wire logic sclOut, // SCL value
  input wire logic sclOe, // SCL pull enable
  input wire logic sdaIn, // SDA level
  input wire logic sdaOut, // SDA value
  input wire logic sdaOe, // SDA pull enable
  input wire logic deepSleep, // Sleep level
  input wire logic wakeReq, // Wake level
  input wire logic irq // Interrupt level
);
  logic wrCtl; // Control write
  logic wrClr; // Control write clearing the flag
  logic enS_r; // Shadow of the enable bit
  logic mskS_r; // Shadow: any mask bit set
  assign wrCtl = busReq.wr && busReq.addr == TWS_ADDR_CTRL;
  assign wrClr = wrCtl && busReq.wdata[TWS_CTRL_FLAG];
  // Shadows of written control and mask bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enS_r <= 1'b0;
      mskS_r <= 1'b0;
    end else begin
      if (wrCtl)
        enS_r <= busReq.wdata[TWS_CTRL_EN];
      if (busReq.wr && busReq.addr == TWS_ADDR_INTMSK)
        mskS_r <= |busReq.wdata[2:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Flag clear while SCL held, then release
  sequence s_clr;
    sclOe ##0 wrClr;
  endsequence
  sequence s_rel;
    ##[1:3] !sclOe;
  endsequence
  property p_rel; s_clr |-> s_rel; endproperty
  a_rel: assert property (p_rel) else $error("SCL not released");
  property p_hold;
    sclOe && !wrClr && !$past(wrClr) && !$past(wrClr, 2) |=> sclOe;
  endproperty
  a_hold: assert property (p_hold) else $error("SCL stretch lost");
  property p_wkd; !deepSleep |=> !wakeReq; endproperty
  a_wkd: assert property (p_wkd) else $error("wake stuck");
  property p_wkh; $rose(wakeReq) |-> ##[0:4] sclOe; endproperty
  a_wkh: assert property (p_wkh) else $error("wake without hold");
  property p_od; !sclOut && !sdaOut; endproperty
  a_od: assert property (p_od) else $error("pin value not low");
  property p_idle; !$past(busReq.rd) |-> rdData == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero");
  property p_pre;
    busReq.rd && busReq.addr == TWS_ADDR_STAT |=> rdData[2:0] == 3'h0;
  endproperty
  a_pre: assert property (p_pre) else $error("status low bits set");
  property p_unm;
    busReq.rd && busReq.addr > TWS_ADDR_INTMSK |=> rdData == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_dis; !enS_r && !$past(enS_r) |-> !sdaOe; endproperty
  a_dis: assert property (p_dis) else $error("drive while disabled");
  property p_irq; !mskS_r |-> !irq; endproperty
  a_irq: assert property (p_irq) else $error("masked interrupt seen");
endmodule // tws_slave_ctrl_chk

//--- tws_master_model.sv
/*
  Behavioural two-wire bus master for the slave bench.
  Assumes open-drain wires with pull-ups resolved by the bench.
*/
`timescale 1ns/100ps
module tws_master_model (
  output logic sclLow, // Master pulls SCL low
  output logic sdaLow, // Master pulls SDA low
  input wire logic scl, // Resolved SCL
  input wire logic sda // Resolved SDA
);
  // Both lines released at start
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  // Release SCL, wait out stretching, keep high
  task automatic rise();
    int n;
    sclLow = 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 50000) begin
      #10;
      n++;
    end
    #40;
  endtask
  // One bit, wire sampled late in the high phase
  task automatic bitx(input logic b, output logic r);
    sdaLow = ~b;
    #30;
    rise();
    r = sda;
    sclLow = 1'b1;
    #10;
  endtask
  // Start or repeated start
  task automatic start();
    // Step off the system clock edge so the wires never race it
    #3;
    sdaLow = 1'b0;
    #30;
    rise();
    sdaLow = 1'b1;
    #40;
    sclLow = 1'b1;
    #10;
  endtask
  // Stop, leaves the bus free
  task automatic stop();
    // Step off the system clock edge so the wires never race it
    #3;
    sdaLow = 1'b1;
    #30;
    rise();
    sdaLow = 1'b0;
    #40;
  endtask
  // Byte MSB first, then the ninth bit
  task automatic xfer(input logic [7:0] d, input logic mAck,
                      output logic [7:0] q, output logic ack);
    // Step off the system clock edge so the wires never race it
    #3;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(mAck, ack);
  endtask
endmodule // tws_master_model

//--- tb_tws_slave_ctrl.sv
/*
  Self-checking bench of the two-wire slave control.
  Assumes the master model and the checker are compiled first.
*/
`timescale 1ns/100ps
module tb_tws_slave_ctrl
  import tws_pkg::*;
;
  logic ref_clk, rst_n, deepSleep; // Clock, reset, sleep
  tws_bus_req_t busReq; // Register request
  logic [7:0] rdData, q, dat; // Read data, scratch
  logic sclOut, sclOe, sdaOut, sdaOe, wakeReq, irq; // Outputs
  logic mSclLow, mSdaLow, scl, sda, ack; // Wires
  logic [6:0] own; // Own address
  int errors, checks; // Counters
  // Open-drain wires with pull-ups
  assign scl = !(mSclLow || sclOe);
  assign sda = !(mSdaLow || sdaOe);
  tws_slave_ctrl DUT (.ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq),
    .rdData(rdData), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .deepSleep(deepSleep),
    .wakeReq(wakeReq), .irq(irq));
  tws_master_model MST (.sclLow(mSclLow), .sdaLow(mSdaLow), .scl(scl),
    .sda(sda));
  always #5 ref_clk = ~ref_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    busReq <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    busReq <= '0;
    #1;
    d = rdData;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  // Wait for the stretch, then compare masked status
  task automatic stat(input logic [7:0] e);
    logic [7:0] s;
    int n;
    n = 0;
    while (sclOe !== 1'b1 && n < 600) begin
      @(posedge ref_clk);
      n++;
    end
    // A stretch that never comes is a mismatch
    if (n >= 600) begin
      errors++;
      $display("ERROR %0t no clock stretch seen", $time);
    end
    rd(TWS_ADDR_STAT, s);
    chk(s & 8'hF8, e);
  endtask
  function automatic logic [7:0] expSt(input logic gc, input logic ak);
    return gc ? (ak ? TWS_ST_GRX_ACK : TWS_ST_GRX_NACK)
              : (ak ? TWS_ST_RX_ACK : TWS_ST_RX_NACK);
  endfunction
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog against a hung bus
  initial begin
    #500000;
    errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    deepSleep = 1'b0;
    busReq = '0;
    errors = 0;
    checks = 0;
    void'($urandom(32'h2732_0334));
    own = 7'($urandom_range(127, 1));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(TWS_ADDR_STAT, q);
    chk(q, TWS_ST_NOINFO);
    rd(TWS_ADDR_CTRL, q);
    chk(q, 8'h00);
    wr(TWS_ADDR_OWN, {own, 1'b1});
    rd(TWS_ADDR_OWN, q);
    chk(q, {own, 1'b1});
    rd(8'h20, q);
    chk(q, 8'h00);
    wr(TWS_ADDR_CTRL, 8'h44);
    wr(TWS_ADDR_INTMSK, 8'h01);
    $display("test registers done");
    MST.start();
    MST.xfer({own, 1'b0}, 1'b1, q, ack);
    chk({7'h00, ack}, 8'h00);
    stat(TWS_ST_SRW);
    chk({7'h00, irq}, 8'h01);
    wr(TWS_ADDR_INTST, 8'h01);
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    for (int k = 0; k < 2; k++) begin
      dat = 8'($urandom);
      wr(TWS_ADDR_CTRL, k == 0 ? 8'hC4 : 8'h84);
      MST.xfer(dat, 1'b1, q, ack);
      chk({7'h00, ack}, 8'(k));
      stat(expSt(1'b0, k == 0));
      rd(TWS_ADDR_DATA, q);
      chk(q, dat);
    end
    wr(TWS_ADDR_CTRL, 8'hC4);
    MST.stop();
    $display("test receive done");
    wr(TWS_ADDR_CTRL, 8'h04);
    MST.start();
    MST.xfer({own, 1'b0}, 1'b1, q, ack);
    chk({7'h00, ack}, 8'h01);
    MST.stop();
    wr(TWS_ADDR_CTRL, 8'h44);
    for (int g = 0; g < 2; g++) begin
      wr(TWS_ADDR_OWN, {own, g[0]});
      MST.start();
      MST.xfer(8'h00, 1'b1, q, ack);
      chk({7'h00, ack}, {7'h00, !g[0]});
      if (g == 1) begin
        stat(TWS_ST_GC);
        wr(TWS_ADDR_CTRL, 8'hC4);
        MST.xfer(8'($urandom), 1'b1, q, ack);
        stat(expSt(1'b1, 1'b1));
        wr(TWS_ADDR_CTRL, 8'hC4);
      end
      MST.stop();
    end
    $display("test general call done");
    MST.start();
    MST.xfer({own, 1'b1}, 1'b1, q, ack);
    stat(TWS_ST_STR);
    dat = 8'($urandom);
    wr(TWS_ADDR_DATA, dat);
    wr(TWS_ADDR_CTRL, 8'h84);
    MST.xfer(8'hFF, 1'b0, q, ack);
    chk(q, dat);
    stat(TWS_ST_TX_LAST);
    wr(TWS_ADDR_CTRL, 8'hE4);
    MST.xfer(8'hFF, 1'b1, q, ack);
    chk(q, 8'hFF);
    // Addressed by another master while own start still pending
    MST.start();
    MST.xfer({own, 1'b0}, 1'b1, q, ack);
    stat(TWS_ST_SRW_ARB);
    wr(TWS_ADDR_CTRL, 8'hC4);
    MST.stop();
    stat(TWS_ST_START);
    chk({7'h00, sdaOe}, 8'h01);
    wr(TWS_ADDR_CTRL, 8'hC4);
    cyc(420);
    chk({7'h00, sdaOe}, 8'h00);
    $display("test transmit done");
    @(posedge ref_clk);
    deepSleep <= 1'b1;
    MST.start();
    MST.xfer({own, 1'b0}, 1'b1, q, ack);
    chk({7'h00, ack}, 8'h00);
    stat(TWS_ST_SRW);
    chk({7'h00, wakeReq}, 8'h01);
    @(posedge ref_clk);
    deepSleep <= 1'b0;
    cyc(5);
    chk({7'h00, sclOe}, 8'h01);
    wr(TWS_ADDR_CTRL, 8'hC4);
    cyc(3);
    chk({7'h00, sclOe}, 8'h00);
    MST.xfer(8'($urandom), 1'b1, q, ack);
    stat(TWS_ST_RX_ACK);
    wr(TWS_ADDR_CTRL, 8'hC4);
    MST.stop();
    $display("test sleep done");
    end_sim();
  end
endmodule // tb_tws_slave_ctrl
bind tws_slave_ctrl tws_slave_ctrl_chk CHK (.ref_clk(ref_clk),
  .rst_n(rst_n), .busReq(busReq), .rdData(rdData), .sclIn(sclIn),
  .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .deepSleep(deepSleep), .wakeReq(wakeReq), .irq(irq));
